/* File: occ_bench.sv */
// Self-checking bench for the operator console block.
// Assumes occ_pkg, occ_console, occ_checker and occ_operator are compiled.
`timescale 1ns/100ps
module operator_console_control_bench;
    localparam logic [4:0] START = 5'h10, HALT = 5'h08, MCLR = 5'h04;
    localparam logic [4:0] SINGLE = 5'h02, REL = 5'h01;
    localparam logic [1:0] CE = 2'h0, UP = 2'h1, DN = 2'h2;
    logic aclk, aresetn, run, repeat_instr, int_enable, mem_wr, mem_rd;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v, rd;
    logic [23:0] display, mem_rdata, mem_wdata, wr_data;
    logic [14:0] ptr_display, p;
    occ_pkg::occ_panel_t panel;
    occ_pkg::occ_lamps_t lamps;
    int miscompares = 0, checked = 0;
    occ_console dut (.*);
    occ_operator op (.aclk(aclk), .panel(panel));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (mem_wr === 1'b1) begin
            wr_data <= mem_wdata;
        end
    end
    // =========================================================
    // Expectations, checks and bus cycles
    function automatic logic [31:0] ptr_of(input logic [31:0] w);
        return {17'h00000, w[23:9]};
    endfunction : ptr_of
    function automatic logic [31:0] ir_of(input logic [31:0] w);
        return {23'h000000, w[8:0]};
    endfunction : ir_of
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 40) begin
            chk("answer within bound", 32'h1, 32'h0);
            give_verdict();
        end
    endtask : tmo
    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask : settle
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask : axi_wr
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        {rd, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(nm, e, rd);
    endtask : rchk
    task automatic wait_run(input logic want);
        int n;
        n = 0;
        while (run !== want && n < 40) begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        chk("run", {31'h0, want}, {31'h0, run});
    endtask : wait_run
    // =========================================================
    // Scenarios
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, mem_rdata} = {32'h0, 4'hF, 24'h0};
        v = $urandom(43);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("pointer", occ_pkg::OFF_PTR, 32'h0);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("unmapped resp", 32'h2, {30'h0, resp});
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 32'h00FFFFFF : {8'h00, 24'($urandom)};
            mem_rdata <= v[23:0];
            op.panel.mem_dir <= DN;
            settle();
            op.press(SINGLE);
            rchk("buffer", occ_pkg::OFF_BUF, v);
            op.panel.mem_dir <= UP;
            settle();
            op.press(SINGLE);
            chk("written", v, {8'h00, wr_data});
            op.panel.ptr_sw <= UP;
            op.panel.instr_load <= UP;
            op.panel.reg_load_hi <= UP;
            settle();
            chk("pointer", ptr_of(v), {17'h0, ptr_display});
            chk("display", v, {8'h00, display});
            rchk("instr", occ_pkg::OFF_INSTR, ir_of(v));
            rchk("acc", occ_pkg::OFF_DISP, v);
            op.panel.ptr_sw <= (i < 2) ? DN : CE;
            op.panel.instr_load <= DN;
            op.panel.reg_load_hi <= DN;
            op.panel.reg_load_lo_dn <= 1'b1;
            settle();
            rchk("pointer", occ_pkg::OFF_PTR, (i < 2) ? 0 : ptr_of(v));
            rchk("instr", occ_pkg::OFF_INSTR, 32'h0);
            rchk("acc", occ_pkg::OFF_DISP, 32'h0);
            rchk("buffer", occ_pkg::OFF_BUF, 32'h0);
            {op.panel.ptr_sw, op.panel.instr_load} <= 4'h0;
            {op.panel.reg_load_hi, op.panel.reg_load_lo_dn} <= 3'h0;
        end
        p = v[23:9];
        $display("test loads done");
        v = {8'h00, 24'($urandom)};
        op.panel.sw_function <= UP;
        op.panel.data_sw <= v[23:0];
        settle();
        rchk("sense", occ_pkg::OFF_SENSE, v);
        rchk("buffer", occ_pkg::OFF_BUF, v);
        op.panel.sw_function <= DN;
        op.panel.data_sw <= {p + 15'h0002, 9'h000};
        settle();
        op.press(START);
        wait_run(1'b1);
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        op.panel.ptr_sw <= DN;
        settle();
        op.panel.ptr_sw <= CE;
        rchk("pointer", occ_pkg::OFF_PTR, {17'h0, p + 15'h1});
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        wait_run(1'b0);
        rchk("pointer", occ_pkg::OFF_PTR, {17'h0, p + 15'h2});
        $display("test halt address done");
        op.panel.sw_function <= CE;
        op.panel.data_sw <= 24'h000000;
        op.panel.step_sw <= DN;
        settle();
        op.press(START);
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        rchk("pointer", occ_pkg::OFF_PTR, {17'h0, p + 15'h3});
        op.panel.step_sw <= UP;
        settle();
        op.press(START);
        axi_wr(occ_pkg::OFF_CTRL, 32'h10);
        wait_run(1'b0);
        rchk("pointer", occ_pkg::OFF_PTR, {17'h0, p + 15'h3});
        op.panel.step_sw <= CE;
        settle();
        op.press(START);
        wait_run(1'b1);
        op.press(HALT);
        wait_run(1'b0);
        $display("test stepping done");
        op.press(START);
        axi_wr(occ_pkg::OFF_CTRL, 32'h01);
        settle();
        chk("io lamp", 32'h1, {31'h0, lamps.io_wait});
        op.press(REL);
        chk("io lamp", 32'h0, {31'h0, lamps.io_wait});
        axi_wr(occ_pkg::OFF_CTRL, 32'h0C);
        op.panel.int_inhibit <= 1'b1;
        settle();
        chk("irq ovf", 32'h3, {30'h0, lamps.irq, lamps.overflow});
        chk("int enable", 32'h0, {31'h0, int_enable});
        op.panel.int_inhibit <= 1'b0;
        settle();
        chk("int enable", 32'h1, {31'h0, int_enable});
        axi_wr(occ_pkg::OFF_CTRL, 32'h02);
        axi_wr(occ_pkg::OFF_CTRL, 32'h00);
        wait_run(1'b0);
        chk("par halt", 32'h3, {30'h0, lamps.parity, lamps.halted});
        op.panel.parity_sw <= DN;
        settle();
        chk("par lamp", 32'h0, {31'h0, lamps.parity});
        op.panel.parity_sw <= CE;
        op.press(MCLR);
        rchk("pointer", occ_pkg::OFF_PTR, 32'h0);
        $display("test lamps and clear done");
        give_verdict();
    end
endmodule : operator_console_control_bench
bind occ_console occ_checker chk_i (.*);

/* File: occ_checker.sv */
// Port checker for the operator console block.
// Assumes raw panel levels pass a two-flop synchroniser before acting.
`timescale 1ns/100ps
module occ_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Front panel
    input wire occ_pkg::occ_panel_t panel,
    input wire occ_pkg::occ_lamps_t lamps,
    // Processor side
    input wire logic [14:0] ptr_display,
    input wire logic run,
    input wire logic repeat_instr,
    input wire logic int_enable,
    input wire logic mem_wr,
    input wire logic mem_rd
);
    // =========================================================
    // Run control and lamps
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A press crosses synchroniser, pulse, state and output stages
    sequence acts(b);
        ##[3:6] b;
    endsequence
    start_runs_a: assert property (
        !run && panel.step_sw == 2'b00 && !panel.halt_pb && !panel.mclr_pb
        && !lamps.io_wait && $rose(panel.start_pb) |-> acts(run))
        else $error("start press did not set run");
    halt_stops_a: assert property (
        run && $rose(panel.halt_pb) |-> acts(!run))
        else $error("halt press did not stop execution");
    clear_all_a: assert property (
        !run && $rose(panel.mclr_pb) |-> acts(ptr_display == 15'h0000))
        else $error("master clear left the pointer set");
    inhibit_blocks_a: assert property (
        panel.int_inhibit [*4] |-> !int_enable)
        else $error("interrupts enabled while inhibited");
    ptr_steps_a: assert property (
        run && $past(run) && ptr_display != $past(ptr_display)
        |-> ptr_display == $past(ptr_display) + 15'h0001)
        else $error("pointer moved by other than one while running");
    repeat_holds_a: assert property (
        repeat_instr |-> $stable(ptr_display))
        else $error("pointer moved during a repeat");
    write_pulse_a: assert property (
        mem_wr |-> !run && !mem_rd ##1 !mem_wr)
        else $error("memory write not a lone halted pulse");
    read_pulse_a: assert property (
        mem_rd |-> !run ##1 !mem_rd)
        else $error("memory read not a lone halted pulse");
    io_release_a: assert property (
        lamps.io_wait && $rose(panel.io_release_pb) |-> acts(!lamps.io_wait))
        else $error("release press did not end the wait");
    parity_halts_a: assert property (
        panel.parity_sw == 2'b00 && lamps.parity && run |-> ##[0:6] !run)
        else $error("parity error with centred switch did not halt");
endmodule : occ_checker

/* File: occ_console.sv */
// Operator console control: front panel switches onto processor registers.
// Assumes panel switches arrive asynchronous and already debounced, and that
// processor events arrive on aclk through an AXI4-Lite control register.
`timescale 1ns/100ps
module occ_console (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Front panel
    input wire occ_pkg::occ_panel_t panel,
    output occ_pkg::occ_lamps_t lamps,
    output logic [23:0] display,
    output logic [14:0] ptr_display,
    // Processor control and memory
    input wire logic [23:0] mem_rdata,
    output logic run,
    output logic repeat_instr,
    output logic int_enable,
    output logic mem_wr,
    output logic mem_rd,
    output logic [23:0] mem_wdata
);

    // =========================================================
    // Switch synchroniser
    localparam int PW = $bits(occ_pkg::occ_panel_t);
    logic [PW-1:0] sync1_r, sync2_r, prev_r;
    occ_pkg::occ_panel_t sw, pr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= panel;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign sw = sync2_r;
    assign pr = prev_r;

    function automatic logic edge_on(input logic now, input logic was);
        edge_on = now & ~was;
    endfunction : edge_on

    // One-cycle pulses from presses and from moving a switch into a position
    logic p_start, p_halt, p_mclr, p_sc, p_iorel;
    logic p_ir_up, p_ir_dn, p_rl_up, p_rl_dn, p_lo_dn, p_pc_up, p_pc_dn;
    logic p_par_dn;
    logic [23:0] p_data;
    assign p_start = edge_on(sw.start_pb, pr.start_pb);
    assign p_halt = edge_on(sw.halt_pb, pr.halt_pb);
    assign p_mclr = edge_on(sw.mclr_pb, pr.mclr_pb);
    assign p_sc = edge_on(sw.single_cycle_pb, pr.single_cycle_pb);
    assign p_iorel = edge_on(sw.io_release_pb, pr.io_release_pb);
    assign p_ir_up = edge_on(sw.instr_load[0], pr.instr_load[0]);
    assign p_ir_dn = edge_on(sw.instr_load[1], pr.instr_load[1]);
    assign p_rl_up = edge_on(sw.reg_load_hi[0], pr.reg_load_hi[0]);
    assign p_rl_dn = edge_on(sw.reg_load_hi[1], pr.reg_load_hi[1]);
    assign p_lo_dn = edge_on(sw.reg_load_lo_dn, pr.reg_load_lo_dn);
    assign p_pc_up = edge_on(sw.ptr_sw[0], pr.ptr_sw[0]);
    assign p_pc_dn = edge_on(sw.ptr_sw[1], pr.ptr_sw[1]);
    assign p_par_dn = edge_on(sw.parity_sw[1], pr.parity_sw[1]);

    // =========================================================
    // Processor events delivered over the register bus
    logic [4:0] ctrl_r;
    logic fetch_pulse;

    // Register load, deposit and single-cycle controls act only while the processor is stopped
    occ_pkg::occ_state_t state_r;
    logic idle;
    assign idle = (state_r == occ_pkg::OCC_ST_HALT);
    assign p_data = idle ? (sw.data_sw & ~pr.data_sw) : 24'h000000;

    // =========================================================
    // Registers of the processor
    logic [23:0] buf_r, acc_r, ext_r;
    logic [14:0] ptr_r, idx1_r, idx2_r, idx3_r;
    logic [8:0] instr_r;
    logic parity_r, halted_r;
    logic halt_match, par_stop;

    // Halt address is compared against the pointer before the fetch
    assign halt_match = (sw.sw_function == occ_pkg::OCC_POS_DOWN)
        && (ptr_r == sw.data_sw[23:9]);
    assign par_stop = parity_r && (sw.parity_sw == occ_pkg::OCC_POS_CENTER);

    logic sc_wr, sc_rd;
    assign sc_wr = idle && p_sc && (sw.mem_dir == occ_pkg::OCC_POS_UP);
    assign sc_rd = idle && p_sc && (sw.mem_dir == occ_pkg::OCC_POS_DOWN);

    // Buffer register
    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            buf_r <= occ_pkg::WORD_RST;
        end else if (mem_rd) begin
            buf_r <= mem_rdata;
        end else if (idle && p_lo_dn) begin
            buf_r <= occ_pkg::WORD_RST;
        end else if (idle && p_rl_dn
                     && sw.disp_a == occ_pkg::OCC_POS_CENTER
                     && sw.disp_b == occ_pkg::OCC_POS_CENTER) begin
            buf_r <= buf_r;
        end else begin
            buf_r <= buf_r | p_data;
        end
    end

    // Instruction register
    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            instr_r <= occ_pkg::IR_RST;
        end else if (idle && p_ir_up) begin
            instr_r <= buf_r[8:0];
        end else if (idle && p_ir_dn) begin
            instr_r <= occ_pkg::IR_RST;
        end
    end

    // Selected register load and clear; with both selectors at center the
    // accumulator takes the transfer, and the buffer is left unchanged.
    logic ld, cl;
    assign ld = idle && p_rl_up;
    assign cl = idle && p_rl_dn;

    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            ext_r <= occ_pkg::WORD_RST;
            idx3_r <= occ_pkg::ADDR_RST;
        end else if (ld || cl) begin
            if (sw.disp_a == occ_pkg::OCC_POS_UP) begin
                ext_r <= ld ? buf_r : occ_pkg::WORD_RST;
            end else if (sw.disp_a == occ_pkg::OCC_POS_DOWN) begin
                idx3_r <= ld ? buf_r[14:0] : occ_pkg::ADDR_RST;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            acc_r <= occ_pkg::WORD_RST;
            idx1_r <= occ_pkg::ADDR_RST;
            idx2_r <= occ_pkg::ADDR_RST;
        end else if (ld || cl) begin
            case (sw.disp_b)
                occ_pkg::OCC_POS_UP: begin
                    idx1_r <= ld ? buf_r[14:0] : occ_pkg::ADDR_RST;
                end
                occ_pkg::OCC_POS_DOWN: begin
                    idx2_r <= ld ? buf_r[14:0] : occ_pkg::ADDR_RST;
                end
                default: begin
                    acc_r <= ld ? buf_r : occ_pkg::WORD_RST;
                end
            endcase
        end
    end

    // Instruction pointer
    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            ptr_r <= occ_pkg::ADDR_RST;
        end else if (idle && p_pc_up) begin
            ptr_r <= buf_r[23:9];
        end else if (idle && p_pc_dn) begin
            ptr_r <= occ_pkg::ADDR_RST;
        end else if (fetch_pulse && !idle && !repeat_instr
                     && !halt_match) begin
            ptr_r <= ptr_r + 15'h0001;
        end
    end

    // Parity latch: set wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            parity_r <= 1'b0;
        end else if (ctrl_r[occ_pkg::CTRL_PARERR]) begin
            parity_r <= 1'b1;
        end else if (p_par_dn) begin
            parity_r <= 1'b0;
        end
    end

    // =========================================================
    // Run control
    always_ff @(posedge aclk) begin
        if (!aresetn || p_mclr) begin
            state_r <= occ_pkg::OCC_ST_HALT;
            halted_r <= 1'b0;
        end else begin
            case (state_r)
                occ_pkg::OCC_ST_HALT: begin
                    if (p_start && sw.step_sw != occ_pkg::OCC_POS_CENTER) begin
                        state_r <= occ_pkg::OCC_ST_STEP;
                        halted_r <= 1'b0;
                    end else if (p_start) begin
                        state_r <= occ_pkg::OCC_ST_RUN;
                        halted_r <= 1'b0;
                    end
                end
                occ_pkg::OCC_ST_RUN: begin
                    if (p_halt || par_stop
                        || (fetch_pulse && halt_match)) begin
                        state_r <= occ_pkg::OCC_ST_HALT;
                        halted_r <= 1'b1;
                    end else if (ctrl_r[occ_pkg::CTRL_IOWAIT]) begin
                        state_r <= occ_pkg::OCC_ST_IOWAIT;
                    end
                end
                occ_pkg::OCC_ST_STEP: begin
                    if (fetch_pulse || p_halt) begin
                        state_r <= occ_pkg::OCC_ST_HALT;
                        halted_r <= 1'b1;
                    end
                end
                occ_pkg::OCC_ST_IOWAIT: begin
                    if (p_iorel || !ctrl_r[occ_pkg::CTRL_IOWAIT]) begin
                        state_r <= occ_pkg::OCC_ST_RUN;
                    end
                end
                default: begin
                    state_r <= occ_pkg::OCC_ST_HALT;
                end
            endcase
        end
    end

    // =========================================================
    // Outputs toward the processor and the panel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            repeat_instr <= 1'b0;
            int_enable <= 1'b0;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            mem_wdata <= occ_pkg::WORD_RST;
            lamps <= '0;
            display <= occ_pkg::WORD_RST;
            ptr_display <= occ_pkg::ADDR_RST;
        end else begin
            run <= (state_r == occ_pkg::OCC_ST_RUN)
                || (state_r == occ_pkg::OCC_ST_STEP);
            repeat_instr <= (state_r == occ_pkg::OCC_ST_STEP)
                && (sw.step_sw == occ_pkg::OCC_POS_UP);
            int_enable <= !sw.int_inhibit;
            mem_wr <= sc_wr;
            mem_rd <= sc_rd;
            mem_wdata <= buf_r;
            lamps.io_wait <= (state_r == occ_pkg::OCC_ST_IOWAIT);
            lamps.parity <= parity_r;
            lamps.irq <= ctrl_r[occ_pkg::CTRL_IRQ];
            lamps.overflow <= ctrl_r[occ_pkg::CTRL_OVF];
            lamps.halted <= halted_r;
            ptr_display <= ptr_r;
            if (sw.disp_a == occ_pkg::OCC_POS_UP) begin
                display <= ext_r;
            end else if (sw.disp_a == occ_pkg::OCC_POS_DOWN) begin
                display <= {9'h000, idx3_r};
            end else begin
                case (sw.disp_b)
                    occ_pkg::OCC_POS_UP: display <= {9'h000, idx1_r};
                    occ_pkg::OCC_POS_DOWN: display <= {9'h000, idx2_r};
                    default: display <= buf_r;
                endcase
            end
        end
    end

    // =========================================================
    // AXI4-Lite slave; one write and one read outstanding
    logic aw_hold_r, w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic do_wr;
    assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign fetch_pulse = do_wr && awaddr_r == occ_pkg::OFF_CTRL
        && wdata_r[occ_pkg::CTRL_FETCH];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl_r <= 5'h00;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready;
            s_axi_wready <= !w_hold_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (p_iorel && state_r == occ_pkg::OCC_ST_IOWAIT) begin
                ctrl_r[occ_pkg::CTRL_IOWAIT] <= 1'b0;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r == occ_pkg::OFF_CTRL)
                    ? 2'b00 : 2'b10;
                if (awaddr_r == occ_pkg::OFF_CTRL) begin
                    ctrl_r <= wdata_r[4:0] & 5'h0F;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    occ_pkg::OFF_CTRL: s_axi_rdata <= {27'h0, ctrl_r};
                    occ_pkg::OFF_STATUS: s_axi_rdata <= {24'h0, 1'b0,
                        parity_r, halted_r, int_enable, state_r, idle, run};
                    occ_pkg::OFF_PTR: s_axi_rdata <= {17'h0, ptr_r};
                    occ_pkg::OFF_BUF: s_axi_rdata <= {8'h0, buf_r};
                    occ_pkg::OFF_INSTR: s_axi_rdata <= {23'h0, instr_r};
                    occ_pkg::OFF_DISP: s_axi_rdata <= {8'h0, acc_r};
                    occ_pkg::OFF_SENSE: begin
                        // Sense switches readable only in sense mode
                        s_axi_rdata <= (sw.sw_function == occ_pkg::OCC_POS_UP)
                            ? {8'h0, sw.data_sw} : 32'h0;
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : occ_console

/* File: occ_operator.sv */
// Operator model: owns the front panel levers and pushbuttons.
// Assumes the bench moves levers through this model's panel output.
`timescale 1ns/100ps
module occ_operator (
    // Clock
    input wire logic aclk,
    // Front panel
    output occ_pkg::occ_panel_t panel
);
    // =========================================================
    // Buttons are held four cycles, well past the synchroniser
    initial panel = '0;
    task automatic press(input logic [4:0] m);
        @(posedge aclk);
        {panel.start_pb, panel.halt_pb, panel.mclr_pb, panel.single_cycle_pb,
            panel.io_release_pb} <= m;
        repeat (4) @(posedge aclk);
        {panel.start_pb, panel.halt_pb, panel.mclr_pb, panel.single_cycle_pb,
            panel.io_release_pb} <= 5'h00;
        repeat (6) @(posedge aclk);
    endtask : press
endmodule : occ_operator

/* File: occ_pkg.sv */
// Shared constants and carriers for the operator console control block.
// Assumes a single 10 MHz processor clock and an AXI4-Lite register port.
package occ_pkg;

    // =========================================================
    // Widths
    localparam int WORD_W = 24;
    localparam int ADDR_W = 15;
    localparam int IR_W = 9;

    // =========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PTR = 8'h08;
    localparam logic [7:0] OFF_BUF = 8'h0C;
    localparam logic [7:0] OFF_INSTR = 8'h10;
    localparam logic [7:0] OFF_DISP = 8'h14;
    localparam logic [7:0] OFF_SENSE = 8'h18;

    // =========================================================
    // Control register bit positions (datapath events from the processor)
    localparam int CTRL_IOWAIT = 0;
    localparam int CTRL_PARERR = 1;
    localparam int CTRL_IRQ = 2;
    localparam int CTRL_OVF = 3;
    localparam int CTRL_FETCH = 4;

    // =========================================================
    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [IR_W-1:0] IR_RST = 9'h000;

    // =========================================================
    // Three-position switch encoding
    typedef enum logic [1:0] {
        OCC_POS_CENTER = 2'b00,
        OCC_POS_UP = 2'b01,
        OCC_POS_DOWN = 2'b10
    } occ_pos_t;

    // Run control states
    typedef enum logic [1:0] {
        OCC_ST_HALT = 2'b00,
        OCC_ST_RUN = 2'b01,
        OCC_ST_STEP = 2'b10,
        OCC_ST_IOWAIT = 2'b11
    } occ_state_t;

    // Front-panel switch bundle (raw, asynchronous)
    typedef struct packed {
        logic [WORD_W-1:0] data_sw;
        logic [1:0] instr_load;
        logic [1:0] reg_load_hi;
        logic reg_load_lo_dn;
        logic [1:0] sw_function;
        logic start_pb;
        logic halt_pb;
        logic mclr_pb;
        logic [1:0] step_sw;
        logic [1:0] mem_dir;
        logic single_cycle_pb;
        logic io_release_pb;
        logic [1:0] parity_sw;
        logic int_inhibit;
        logic [1:0] disp_a;
        logic [1:0] disp_b;
        logic [1:0] ptr_sw;
    } occ_panel_t;

    // Lamp bundle
    typedef struct packed {
        logic io_wait;
        logic parity;
        logic irq;
        logic overflow;
        logic halted;
    } occ_lamps_t;

endpackage : occ_pkg
